// ===== verilog/ito_pkg.sv
// Package with constants and types of the I2C slave bus time-out block
package ito_pkg;
  // ***********************************************************************
  // Register map (Avalon word addresses, byte address = 4 * index)
  // ***********************************************************************
  localparam logic [2:0] ADDR_TIMEOUT_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_IRQ_STATUS      = 3'h1;
  localparam logic [2:0] ADDR_IRQ_CLEAR       = 3'h2;
  localparam logic [2:0] ADDR_IRQ_ENABLE      = 3'h3;
  localparam logic [2:0] ADDR_SERIAL_CTRL2    = 3'h4;
  localparam logic [2:0] ADDR_SLAVE_ADDRESS   = 3'h5;

  // ***********************************************************************
  // Field positions and reset values
  // ***********************************************************************
  localparam int          BIT_ENABLE        = 7;
  localparam int          BIT_FLAG          = 6;
  localparam int          PERIOD_MSB        = 5;
  localparam logic [7:0]  TOC_RESET         = 8'h00;
  localparam logic [3:0]  CTRL2_RESET       = 4'h1;
  localparam logic [6:0]  SLAVE_ADDR_RESET  = 7'h00;
  localparam logic [1:0]  IRQ_RESET         = 2'h0;
  localparam int          IRQ_BIT_MATCH     = 0;
  localparam int          IRQ_BIT_TIMEOUT   = 1;
  localparam int          CTRL2_BIT_MATCH   = 3;
  localparam int          CTRL2_BIT_RW      = 2;

  // ***********************************************************************
  // Timing: subsidiary clock divided by 32 for the time-out tick
  // ***********************************************************************
  localparam int          SUB_DIVIDE        = 32;
  localparam logic [4:0]  SUB_DIV_LAST      = 5'(SUB_DIVIDE - 1);

  // Watchdog states
  typedef enum logic [2:0] {
    ITO_IDLE  = 3'b001,
    ITO_ADDR  = 3'b010,
    ITO_WATCH = 3'b100
  } ito_state_t;
endpackage : ito_pkg

// ===== verilog/ito_tick_if.sv
// Interface carrying the divided tick between divider and top
`timescale 1ns/1ns
interface ito_tick_if;
  logic sub_edge;   // Rising edge seen on subsidiary clock
  logic tick;       // One pulse per 32 subsidiary periods
  modport src (input sub_edge, output tick);
  modport dst (output sub_edge, input tick);
endinterface : ito_tick_if

// ===== verilog/ito_tick_div.sv
// Divider of subsidiary clock edges by 32
`timescale 1ns/1ns
module ito_tick_div (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Tick carrier
  ito_tick_if.src   tk
);
  import ito_pkg::*;

  logic [4:0] div_count;
  logic       next_tick;

  // Tick on the last of 32 subsidiary edges
  assign next_tick = tk.sub_edge && (div_count == SUB_DIV_LAST);

  // Count subsidiary edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_count <= 5'h00;
      tk.tick   <= 1'b0;
    end else begin
      tk.tick <= next_tick;
      if (tk.sub_edge) begin
        div_count <= div_count + 5'h01;
      end
    end
  end
endmodule : ito_tick_div

// ===== verilog/ito_bus_timeout.sv
// I2C slave bus time-out watchdog with Avalon-MM register slave
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns

module ito_bus_timeout (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Events from the I2C engine
  input  wire logic        sub_clk_edge_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        addr_valid_i,
  input  wire logic [6:0]  addr_rx_i,
  input  wire logic        rw_rx_i,
  input  wire logic        scl_fall_i,
  // Outputs to the I2C engine and CPU
  output logic             i2c_reset_o,
  output logic             irq_o
);
  import ito_pkg::*;

  // *********************************************************************
  // Declarations
  // *********************************************************************
  ito_tick_if  tk ();
  ito_state_t  state;
  ito_state_t  next_state;
  logic [7:0]  toc;            // i2c_timeout_control
  logic [3:0]  ctrl2;          // serial_control_second subset
  logic [6:0]  slave_addr;     // slave_address_register
  logic [1:0]  irq_status;
  logic [1:0]  irq_enable;
  logic [5:0]  tick_count;
  logic        ack_pending;
  logic        timeout_enable;
  logic        timeout_flag;
  logic [5:0]  timeout_period_select;
  logic        addr_match;
  logic        watching;
  logic        overflow;
  logic        access;
  logic        wr_toc;
  logic        wr_clear;
  logic        wr_enable;
  logic        wr_ctrl2;
  logic        wr_addr;
  logic [31:0] next_readdata;
  logic [1:0]  events;

  // *********************************************************************
  // Tick divider
  // *********************************************************************
  assign tk.sub_edge = sub_clk_edge_i;

  ito_tick_div u_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tk    (tk.src)
  );

  // *********************************************************************
  // Field views and event decode
  // *********************************************************************
  assign timeout_enable        = toc[BIT_ENABLE];
  assign timeout_flag          = toc[BIT_FLAG];
  assign timeout_period_select = toc[PERIOD_MSB:0];
  assign addr_match  = addr_valid_i && (addr_rx_i == slave_addr);
  assign watching    = (state == ITO_WATCH) && timeout_enable;
  // Overflow when tick count reaches (select+1) ticks, no SCL fall now
  assign overflow    = watching && tk.tick && !scl_fall_i &&
                       (tick_count == timeout_period_select);
  assign events      = {overflow, addr_match};

  // *********************************************************************
  // Avalon decode: one wait cycle, answer on second cycle
  // *********************************************************************
  assign access            = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = access && !ack_pending;
  assign wr_toc    = avs_write_i && ack_pending &&
                     (avs_address_i == ADDR_TIMEOUT_CONTROL);
  assign wr_clear  = avs_write_i && ack_pending &&
                     (avs_address_i == ADDR_IRQ_CLEAR);
  assign wr_enable = avs_write_i && ack_pending &&
                     (avs_address_i == ADDR_IRQ_ENABLE);
  assign wr_ctrl2  = avs_write_i && ack_pending &&
                     (avs_address_i == ADDR_SERIAL_CTRL2);
  assign wr_addr   = avs_write_i && ack_pending &&
                     (avs_address_i == ADDR_SLAVE_ADDRESS);

  // Read data selection
  always_comb begin
    if (avs_address_i == ADDR_TIMEOUT_CONTROL) begin
      next_readdata = {24'h000000, toc};
    end else if (avs_address_i == ADDR_IRQ_STATUS) begin
      next_readdata = {30'h0, irq_status};
    end else if (avs_address_i == ADDR_IRQ_ENABLE) begin
      next_readdata = {30'h0, irq_enable};
    end else if (avs_address_i == ADDR_SERIAL_CTRL2) begin
      next_readdata = {28'h0000000, ctrl2};
    end else if (avs_address_i == ADDR_SLAVE_ADDRESS) begin
      next_readdata = {25'h0, slave_addr};
    end else begin
      next_readdata = 32'h00000000;
    end
  end

  // Bus handshake and read data register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_pending    <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_pending <= access && !ack_pending;
      if (avs_read_i && !ack_pending) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

  // *********************************************************************
  // Watchdog state machine
  // *********************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ITO_IDLE: begin
        if (start_i) begin
          next_state = ITO_ADDR;
        end
      end
      ITO_ADDR: begin
        if (addr_match) begin
          next_state = ITO_WATCH;
        end else if (addr_valid_i || stop_i) begin
          next_state = ITO_IDLE;
        end
      end
      ITO_WATCH: begin
        if (stop_i || overflow) begin
          next_state = ITO_IDLE;
        end else if (start_i) begin
          next_state = ITO_ADDR;
        end
      end
      default: begin
        next_state = ITO_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ITO_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // *********************************************************************
  // Tick counter: counts divided ticks, cleared by SCL falls
  // *********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_count <= 6'h00;
    end else if (!watching || scl_fall_i || overflow) begin
      tick_count <= 6'h00;
    end else if (tk.tick) begin
      tick_count <= tick_count + 6'h01;
    end
  end

  // *********************************************************************
  // Time-out control register
  // *********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      toc <= TOC_RESET;
    end else begin
      if (wr_toc) begin
        toc <= avs_writedata_i[7:0];
      end
      if (overflow) begin
        toc[BIT_ENABLE] <= 1'b0;
        toc[BIT_FLAG]   <= 1'b1;
      end
    end
  end

  // *********************************************************************
  // Second control register and slave address
  // *********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl2      <= CTRL2_RESET;
      slave_addr <= SLAVE_ADDR_RESET;
    end else begin
      if (wr_addr) begin
        slave_addr <= avs_writedata_i[6:0];
      end
      if (overflow) begin
        ctrl2 <= CTRL2_RESET;
      end else if (addr_match) begin
        ctrl2[CTRL2_BIT_MATCH] <= 1'b1;
        ctrl2[CTRL2_BIT_RW]    <= rw_rx_i;
      end else if (wr_ctrl2) begin
        ctrl2 <= avs_writedata_i[3:0];
      end
    end
  end

  // *********************************************************************
  // Interrupt status and enable; set wins over clear
  // *********************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= IRQ_RESET;
      irq_enable <= IRQ_RESET;
    end else begin
      irq_status <= (irq_status &
                     ~(wr_clear ? avs_writedata_i[1:0] : 2'h0)) |
                    events;
      if (wr_enable) begin
        irq_enable <= avs_writedata_i[1:0];
      end
    end
  end

  // Engine reset pulse and interrupt level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      i2c_reset_o <= 1'b0;
    end else begin
      i2c_reset_o <= overflow;
    end
  end

  assign irq_o = |(irq_status & irq_enable);
endmodule : ito_bus_timeout

// ===== testbench/ito_bus_timeout_chk.sv
// Assertion checker of the I2C slave bus time-out block
`timescale 1ns/1ns
module ito_bus_timeout_chk
  import ito_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Avalon-MM slave
  input wire logic [2:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Engine side
  input wire logic        stop_i,
  input wire logic        i2c_reset_o,
  input wire logic        irq_o
);
  logic flag_seen;  // Time-out flag known to be set
  wire  wr_take = avs_write_i && !avs_waitrequest_o;
  wire  rd_take = avs_read_i && !avs_waitrequest_o;
  wire  toc_wr  = wr_take && avs_address_i == ADDR_TIMEOUT_CONTROL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Follows the flag from the reset pulse to the clearing write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) flag_seen <= 1'h0;
    else if (toc_wr && !avs_writedata_i[BIT_FLAG]) flag_seen <= 1'h0;
    else if (i2c_reset_o) flag_seen <= 1'h1;
  end
  wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bad wait");
  wait_idle_a: assert property (!avs_read_i && !avs_write_i |->
    !avs_waitrequest_o) else $error("wait while idle");
  unmapped_zero_a: assert property (rd_take && (avs_address_i > 3'h5 ||
    avs_address_i == ADDR_IRQ_CLEAR) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  reset_pulse_a: assert property (i2c_reset_o |=> !i2c_reset_o)
    else $error("engine reset too long");
  stop_quiet_a: assert property (stop_i |-> ##2 !i2c_reset_o [*8])
    else $error("time-out after stop");
  disable_quiet_a: assert property (toc_wr &&
    !avs_writedata_i[BIT_ENABLE] |-> ##2 !i2c_reset_o [*8])
    else $error("time-out after disable");
  irq_mask_a: assert property (wr_take &&
    avs_address_i == ADDR_IRQ_ENABLE && avs_writedata_i[1:0] == 2'h0
    |=> !irq_o) else $error("masked irq high");
  flag_sticky_a: assert property (rd_take && flag_seen &&
    avs_address_i == ADDR_TIMEOUT_CONTROL |-> avs_readdata_o[BIT_FLAG])
    else $error("flag lost");
endmodule : ito_bus_timeout_chk

bind ito_bus_timeout ito_bus_timeout_chk i_chk (.*);

// ===== testbench/ito_i2c_master_model.sv
// Model of the external I2C master, seen through the engine events
`timescale 1ns/1ns
module ito_i2c_master_model (
  // Clock
  input  wire logic clk_i,
  // Engine events
  output logic       sub_edge_o,
  output logic       start_o,
  output logic       stop_o,
  output logic       addr_valid_o,
  output logic [6:0] addr_o,
  output logic       rw_o,
  output logic       scl_fall_o
);
  // Idle bus at time zero
  initial begin
    {sub_edge_o, start_o, stop_o, addr_valid_o, rw_o, scl_fall_o} = 6'h0;
    addr_o = 7'h7F;
  end
  // Subsidiary clock edge every second cycle
  always @(posedge clk_i) sub_edge_o <= !sub_edge_o;
  // START, then the address; lines inverted once released
  task send_address(input logic [6:0] a);
    @(posedge clk_i);
    start_o <= 1'h1;
    @(posedge clk_i);
    start_o      <= 1'h0;
    addr_valid_o <= 1'h1;
    addr_o       <= a;
    rw_o         <= 1'h0;
    @(posedge clk_i);
    addr_valid_o <= 1'h0;
    addr_o       <= ~a;
    rw_o         <= 1'h1;
  endtask : send_address
  // One SCL falling edge
  task scl_edge;
    @(posedge clk_i);
    scl_fall_o <= 1'h1;
    @(posedge clk_i);
    scl_fall_o <= 1'h0;
  endtask : scl_edge
  // STOP condition
  task stop_bus;
    @(posedge clk_i);
    stop_o <= 1'h1;
    @(posedge clk_i);
    stop_o <= 1'h0;
  endtask : stop_bus
endmodule : ito_i2c_master_model

// ===== testbench/ito_bus_timeout_tb_top.sv
// Self-checking testbench of the I2C slave bus time-out block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH at %0t got %h exp %h", $time, g, e); \
  end end
module ito_bus_timeout_tb_top;
  import ito_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [2:0]  avs_address_i = 3'h0;
  logic        avs_read_i = 1'h0;
  logic        avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rd;
  logic        avs_waitrequest_o, i2c_reset_o, irq_o;
  logic        sub_edge, start, stop, addr_valid, rw, scl_fall;
  logic [6:0]  addr_rx;
  int          n_mismatch, check_count, cyc, n_rst, t_fall;
  always #20 clk_i = ~clk_i;
  ito_bus_timeout i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sub_clk_edge_i(sub_edge), .start_i(start), .stop_i(stop),
    .addr_valid_i(addr_valid), .addr_rx_i(addr_rx), .rw_rx_i(rw),
    .scl_fall_i(scl_fall), .i2c_reset_o(i2c_reset_o), .irq_o(irq_o));
  ito_i2c_master_model i_mst (.clk_i(clk_i), .sub_edge_o(sub_edge),
    .start_o(start), .stop_o(stop), .addr_valid_o(addr_valid),
    .addr_o(addr_rx), .rw_o(rw), .scl_fall_o(scl_fall));
  // Cycle count, engine reset count and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (i2c_reset_o === 1'h1) n_rst++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Avalon-MM transfer held until waitrequest is seen low
  task bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 20);
    `CHK(avs_waitrequest_o, 1'h0)
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i  <= 1'h0;
  endtask : bus
  task chk_rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk_rd
  // Idle cycles, or until the engine reset is seen
  task idle(input int lim);
    for (int i = 0; i < lim && i2c_reset_o !== 1'h1; i++) @(posedge clk_i);
  endtask : idle
  // Reset values, read-back, unmapped and write-only places
  task t_regs;
    chk_rd(ADDR_TIMEOUT_CONTROL, 32'h0);
    chk_rd(ADDR_SERIAL_CTRL2, 32'(CTRL2_RESET));
    chk_rd(ADDR_IRQ_STATUS, 32'h0);
    bus(1'h1, ADDR_TIMEOUT_CONTROL, 32'h3F);
    chk_rd(ADDR_TIMEOUT_CONTROL, 32'h3F);
    bus(1'h1, 3'h6, 32'hFF);
    chk_rd(3'h6, 32'h0);
    chk_rd(ADDR_IRQ_CLEAR, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  // Matched frame, edges in time, then a stall until time-out
  task t_timeout;
    bus(1'h1, ADDR_SLAVE_ADDRESS, 32'h2A);
    bus(1'h1, ADDR_IRQ_ENABLE, 32'h3);
    bus(1'h1, ADDR_TIMEOUT_CONTROL, 32'h81);
    n_rst = 0;
    i_mst.send_address(7'h2A);
    chk_rd(ADDR_IRQ_STATUS, 32'h1);
    `CHK(irq_o, 1'h1)
    bus(1'h1, ADDR_IRQ_CLEAR, 32'h1);
    repeat (4) begin
      repeat (50) @(posedge clk_i);
      i_mst.scl_edge();
    end
    `CHK(n_rst, 0)
    t_fall = cyc;
    idle(300);
    `CHK(cyc - t_fall > 2 * SUB_DIVIDE && cyc - t_fall <= 4 * SUB_DIVIDE + 6, 1'h1)
    repeat (3) @(posedge clk_i);
    `CHK(n_rst, 1)
    `CHK(irq_o, 1'h1)
    chk_rd(ADDR_IRQ_STATUS, 32'h2);
    chk_rd(ADDR_TIMEOUT_CONTROL, 32'h41);
    chk_rd(ADDR_SERIAL_CTRL2, 32'(CTRL2_RESET));
    chk_rd(ADDR_SLAVE_ADDRESS, 32'h2A);
    repeat (200) @(posedge clk_i);
    chk_rd(ADDR_TIMEOUT_CONTROL, 32'h41);
    bus(1'h1, ADDR_TIMEOUT_CONTROL, 32'h01);
    bus(1'h1, ADDR_IRQ_CLEAR, 32'h3);
    chk_rd(ADDR_TIMEOUT_CONTROL, 32'h1);
    `CHK(irq_o, 1'h0)
    $display("t_timeout done");
  endtask : t_timeout
  // Wrong address, STOP and disable never time out; masked irq
  task t_quiet;
    bus(1'h1, ADDR_IRQ_ENABLE, 32'h0);
    bus(1'h1, ADDR_TIMEOUT_CONTROL, 32'h81);
    i_mst.send_address(7'h15);
    idle(200);
    chk_rd(ADDR_IRQ_STATUS, 32'h0);
    `CHK(n_rst, 1)
    i_mst.send_address(7'h2A);
    i_mst.stop_bus();
    idle(200);
    `CHK(n_rst, 1)
    `CHK(irq_o, 1'h0)
    chk_rd(ADDR_IRQ_STATUS, 32'h1);
    i_mst.send_address(7'h2A);
    bus(1'h1, ADDR_TIMEOUT_CONTROL, 32'h01);
    idle(200);
    `CHK(n_rst, 1)
    chk_rd(ADDR_TIMEOUT_CONTROL, 32'h1);
    $display("t_quiet done");
  endtask : t_quiet
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs();
    t_timeout();
    t_quiet();
    report_and_stop();
  end
endmodule : ito_bus_timeout_tb_top
